// [hw/ccrs_pkg.sv]
package ccrs_pkg;

   // apb register byte offsets
   localparam logic [7:0] CCRS_CTRL_OFS   = 8'h00;
   localparam logic [7:0] CCRS_FMT_OFS    = 8'h04;
   localparam logic [7:0] CCRS_STATUS_OFS = 8'h08;
   localparam logic [7:0] CCRS_TEST_OFS   = 8'h0c;

   // control register fields
   localparam int CCRS_CTRL_MCW_BIT = 0;
   localparam int CCRS_CTRL_CAL_BIT = 1;

   // data format register fields
   localparam int CCRS_FMT_CDS_LSB = 0;
   localparam int CCRS_FMT_CSS_BIT = 3;
   localparam int CCRS_FMT_ENC_LSB = 4;

   // status register fields
   localparam int CCRS_ST_CIP_BIT  = 0;
   localparam int CCRS_ST_RSY_BIT  = 1;
   localparam int CCRS_ST_MUTE_BIT = 2;
   localparam int CCRS_ST_TMO_BIT  = 3;

   // reset values
   localparam logic [1:0] CCRS_CTRL_RST = 2'h0;
   localparam logic [5:0] CCRS_FMT_RST  = 6'h00;

   // sample period counts
   localparam int CCRS_CAL_PERIODS  = 384;
   localparam int CCRS_MUTE_PERIODS = 128;

   // log2 of the first resync time-out in reference clock periods
   localparam int CCRS_RESYNC_LOG2 = 21;

   localparam logic [31:0] CCRS_BAD_DATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      CCRS_ENC_S16  = 2'b00,
      CCRS_ENC_U8   = 2'b01,
      CCRS_ENC_ULAW = 2'b10,
      CCRS_ENC_ALAW = 2'b11
   } ccrs_enc_t;

   typedef enum logic [1:0] {
      CCRS_RS_IDLE = 2'b00,
      CCRS_RS_WAIT = 2'b01,
      CCRS_RS_TMO  = 2'b10,
      CCRS_RS_SYNC = 2'b11
   } ccrs_rs_t;

endpackage

// [hw/ccrs_sequencer.sv]
`timescale 1ns/1ps
module ccrs_sequencer
   import ccrs_pkg::*;
#(
   parameter int FRAME_SAMPLES = 2,
   parameter int TMO_FIRST     = 1 << CCRS_RESYNC_LOG2,
   parameter int TMO_LATER     = 61440
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        i_sample_tick,
   input  wire logic        i_frame_sync,
   input  wire logic [15:0] i_pcm_sample,
   output logic      [15:0] o_enc_sample,
   output logic             o_mute,
   output logic             o_frame_sync_en,
   output logic             o_cal_run
);

   typedef struct packed {
      logic [1:0]  fs_sync;
      logic        fs_prev;
      logic        mcw;
      logic        cal_req;
      logic [5:0]  fmt;
      logic        cip;
      logic        cal_mode;
      logic [8:0]  smp_cnt;
      ccrs_rs_t    rs;
      logic        resync;
      logic        powered_once;
      logic [21:0] tmo_cnt;
      logic [7:0]  frm_cnt;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic [15:0] enc;
   } ccrs_state_t;

   ccrs_state_t s_r;
   ccrs_state_t s_nxt;

   // mu-law: bias, find segment, invert
   function automatic logic [7:0] enc_ulaw(input logic [15:0] x);
      logic [15:0] mag;
      logic [2:0]  seg;
      logic [3:0]  man;
      mag = x[15] ? 16'((~x) + 16'h0001) : x;
      mag = 16'(mag >> 2);
      if (mag > 16'h1fdf) begin
         mag = 16'h1fdf;
      end
      mag = 16'(mag + 16'h0021);
      seg = 3'h7;
      for (int k = 6; k >= 0; k--) begin
         if (mag < (16'h0040 << k)) begin
            seg = 3'(k);
         end
      end
      man = 4'((mag >> (4'(seg) + 4'h1)) & 16'h000f);
      // clipped peak lands past the top segment: saturate the code
      if (mag >= 16'h2000) begin
         seg = 3'h7;
         man = 4'hf;
      end
      enc_ulaw = ~{x[15], seg, man};
   endfunction

   // a-law: segment from magnitude, even bits toggled
   function automatic logic [7:0] enc_alaw(input logic [15:0] x);
      logic [15:0] mag;
      logic [2:0]  seg;
      logic [3:0]  man;
      mag = x[15] ? 16'(~x) : x;
      mag = 16'(mag >> 3);
      seg = 3'h0;
      for (int k = 1; k < 8; k++) begin
         if (mag >= (16'h0020 << (k - 1))) begin
            seg = 3'(k);
         end
      end
      if (seg == 3'h0) begin
         man = 4'(mag >> 1);
      end else begin
         man = 4'(mag >> seg);
      end
      enc_alaw = {~x[15], seg, man} ^ 8'h55;
   endfunction

   logic fs_edge;
   logic wr_en;
   logic rd_en;
   logic fmt_wr;
   logic [8:0] term;

   always_comb begin
      s_nxt = s_r;
      // first stage feeds only the second
      s_nxt.fs_sync = {s_r.fs_sync[0], i_frame_sync};
      s_nxt.fs_prev = s_r.fs_sync[1];
      fs_edge = s_r.fs_sync[1] & ~s_r.fs_prev;
      wr_en  = psel & penable & pwrite & ~s_r.ready;
      rd_en  = psel & penable & ~pwrite & ~s_r.ready;
      fmt_wr = 1'b0;
      term   = s_r.cal_mode ? 9'(CCRS_CAL_PERIODS - 1) : 9'(CCRS_MUTE_PERIODS - 1);

      // apb: one wait state, answer registered
      s_nxt.ready  = psel & penable & ~s_r.ready;
      s_nxt.slverr = 1'b0;
      s_nxt.rdata  = CCRS_BAD_DATA;

      // calibration / mute interval timer
      if (s_r.cip && i_sample_tick) begin
         if (s_r.smp_cnt == term) begin
            s_nxt.cip = 1'b0;
         end else begin
            s_nxt.smp_cnt = 9'(s_r.smp_cnt + 9'h001);
         end
      end

      if (wr_en) begin
         unique case (paddr)
            CCRS_CTRL_OFS: begin
               s_nxt.mcw = pwdata[CCRS_CTRL_MCW_BIT];
               // calibration request alterable in window or by the write that opens it
               if (s_r.mcw || pwdata[CCRS_CTRL_MCW_BIT]) begin
                  s_nxt.cal_req = pwdata[CCRS_CTRL_CAL_BIT];
               end
               if (s_r.mcw && !pwdata[CCRS_CTRL_MCW_BIT]) begin
                  s_nxt.cip      = 1'b1;
                  s_nxt.smp_cnt  = 9'h000;
                  s_nxt.cal_mode = s_r.cal_req;
               end
            end
            CCRS_FMT_OFS: begin
               // format written only while the window is already open
               if (s_r.mcw) begin
                  s_nxt.fmt = pwdata[5:0];
                  fmt_wr = 1'b1;
               end
            end
            default: begin
               s_nxt.slverr = ~(paddr == CCRS_STATUS_OFS);
            end
         endcase
      end
      if (rd_en) begin
         unique case (paddr)
            CCRS_CTRL_OFS:   s_nxt.rdata = {30'h0, s_r.cal_req, s_r.mcw};
            CCRS_FMT_OFS:    s_nxt.rdata = {26'h0, s_r.fmt};
            CCRS_STATUS_OFS: begin
               s_nxt.rdata = {28'h0, (s_r.rs == CCRS_RS_TMO),
                              (s_r.cip & ~s_r.cal_mode), s_r.resync, s_r.cip};
            end
            default: begin
               s_nxt.slverr = 1'b1;
            end
         endcase
      end

      // resynchronisation sequencer
      unique case (s_r.rs)
         CCRS_RS_IDLE: begin
            if (fmt_wr && (pwdata[3:0] != s_r.fmt[3:0])) begin
               s_nxt.rs      = CCRS_RS_WAIT;
               s_nxt.frm_cnt = 8'h00;
               s_nxt.resync  = 1'b0;
            end
         end
         CCRS_RS_WAIT: begin
            if (i_sample_tick) begin
               if (s_r.frm_cnt == 8'(2 * FRAME_SAMPLES - 1)) begin
                  s_nxt.resync  = 1'b1;
                  s_nxt.rs      = CCRS_RS_TMO;
                  s_nxt.tmo_cnt = s_r.powered_once ? 22'(TMO_LATER - 1)
                                                   : 22'(TMO_FIRST - 1);
               end else begin
                  s_nxt.frm_cnt = 8'(s_r.frm_cnt + 8'h01);
               end
            end
         end
         CCRS_RS_TMO: begin
            // frame syncs here are ignored
            if (s_r.tmo_cnt == 22'h0) begin
               s_nxt.rs           = CCRS_RS_SYNC;
               s_nxt.powered_once = 1'b1;
            end else begin
               s_nxt.tmo_cnt = 22'(s_r.tmo_cnt - 22'h1);
            end
         end
         CCRS_RS_SYNC: begin
            if (fs_edge) begin
               s_nxt.rs = CCRS_RS_IDLE;
            end
         end
      endcase

      // encoder, fed from sample stream
      unique case (ccrs_enc_t'(s_r.fmt[5:4]))
         CCRS_ENC_S16:  s_nxt.enc = i_pcm_sample;
         CCRS_ENC_U8:   s_nxt.enc = {8'h00, ~i_pcm_sample[15], i_pcm_sample[14:8]};
         CCRS_ENC_ULAW: s_nxt.enc = {8'h00, enc_ulaw(i_pcm_sample)};
         CCRS_ENC_ALAW: s_nxt.enc = {8'h00, enc_alaw(i_pcm_sample)};
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r         <= '0;
         s_r.cal_req <= CCRS_CTRL_RST[CCRS_CTRL_CAL_BIT];
         s_r.fmt     <= CCRS_FMT_RST;
         s_r.rs      <= CCRS_RS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mute          <= 1'b0;
         o_frame_sync_en <= 1'b1;
         o_cal_run       <= 1'b0;
      end else begin
         o_mute          <= s_nxt.cip & ~s_nxt.cal_mode;
         o_frame_sync_en <= ~((s_nxt.rs == CCRS_RS_TMO) || (s_nxt.rs == CCRS_RS_SYNC));
         o_cal_run       <= s_nxt.cip & s_nxt.cal_mode;
      end
   end

   assign prdata       = s_r.rdata;
   assign pready       = s_r.ready;
   assign pslverr      = s_r.slverr;
   assign o_enc_sample = s_r.enc;

   a_close_sets_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (psel && penable && pwrite && !pready && paddr == CCRS_CTRL_OFS && s_r.mcw
       && !pwdata[CCRS_CTRL_MCW_BIT]) |=> s_r.cip)
      else $error("window close did not raise flag");

   a_fmt_locked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!s_r.mcw) |=> (s_r.fmt == $past(s_r.fmt)))
      else $error("format changed outside window");

   a_cal_length: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ($fell(s_r.cip) && s_r.cal_mode) |-> ($past(s_r.smp_cnt) == 9'(CCRS_CAL_PERIODS - 1)))
      else $error("calibration interval wrong");

   a_mute_length: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ($fell(s_r.cip) && !s_r.cal_mode) |-> ($past(s_r.smp_cnt) == 9'(CCRS_MUTE_PERIODS - 1)))
      else $error("mute interval wrong");

   a_mute_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.cip && !s_r.cal_mode) |-> o_mute)
      else $error("mute not driven");

   a_no_sync_tmo: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.rs == CCRS_RS_TMO) |=> !o_frame_sync_en)
      else $error("frame syncs during time-out");

   a_resync_seen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.rs == CCRS_RS_WAIT ##1 s_r.rs == CCRS_RS_TMO) |-> s_r.resync)
      else $error("resync flag missing");

   a_resume_sync: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.rs == CCRS_RS_SYNC && fs_edge) |=> (s_r.rs == CCRS_RS_IDLE) ##1 o_frame_sync_en)
      else $error("no resume after frame sync");

   a_u8_sign: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.fmt[5:4] == 2'b01 && $stable(s_r.fmt)) |=> (s_r.enc[7] == !$past(i_pcm_sample[15])))
      else $error("unsigned sign bit wrong");

   a_cal_run_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_cal_run |-> s_r.cip)
      else $error("calibration runs without flag");

   a_cnt_bound: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_r.cip |-> (s_r.smp_cnt <= term))
      else $error("interval counter past terminal count");

   a_cnt_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.cip && !i_sample_tick && !wr_en) |=> $stable(s_r.smp_cnt))
      else $error("interval counter moved without tick");

   a_tmo_ignores_fs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.rs == CCRS_RS_TMO && s_r.tmo_cnt != 22'h0) |=> (s_r.rs == CCRS_RS_TMO))
      else $error("time-out left early");

   a_fmt_open_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (wr_en && paddr == CCRS_FMT_OFS && s_r.mcw) |=> (s_r.fmt == $past(pwdata[5:0])))
      else $error("format write in window lost");

   a_rate_starts: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.rs == CCRS_RS_IDLE && fmt_wr && pwdata[3:0] != s_r.fmt[3:0])
      |=> (s_r.rs == CCRS_RS_WAIT))
      else $error("clock change did not start resync");

   a_cal_starts: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (wr_en && paddr == CCRS_CTRL_OFS && s_r.mcw && !pwdata[CCRS_CTRL_MCW_BIT]
       && s_r.cal_req) |=> (s_r.cal_mode && o_cal_run))
      else $error("calibration not started on close");

   a_sync_dark: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.rs == CCRS_RS_SYNC) |-> !o_frame_sync_en)
      else $error("frame syncs before first sync");

   a_s16_pass: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.fmt[5:4] == 2'b00 && $stable(s_r.fmt)) |=> (s_r.enc == $past(i_pcm_sample)))
      else $error("signed sample altered");

   a_u8_high_byte: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_r.fmt[5:4] == 2'b01 && $stable(s_r.fmt))
      |=> (s_r.enc[6:0] == $past(i_pcm_sample[14:8]) && s_r.enc[15:8] == 8'h00))
      else $error("unsigned high byte wrong");

endmodule

// [test/ccrs_host_model.sv]
`timescale 1ns/1ps
module ccrs_host_model #(
   parameter int TICK_DIV      = 4,
   parameter int FRAME_SAMPLES = 2
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   output logic      o_sample_tick,
   output logic      o_frame_sync
);
   int div_cnt;
   int smp_cnt;
   // frame sync runs free: the device must ignore it while it resyncs
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         div_cnt <= 0;
         smp_cnt <= 0;
         o_sample_tick <= 1'b0;
         o_frame_sync <= 1'b0;
      end else begin
         o_sample_tick <= (div_cnt == TICK_DIV - 1);
         div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
         if (div_cnt == TICK_DIV - 1) begin
            smp_cnt <= (smp_cnt + 1) % FRAME_SAMPLES;
         end
         o_frame_sync <= (smp_cnt == 0);
      end
   end
endmodule

// [test/test_ccrs_sequencer.sv]
`timescale 1ns/1ps
module test_ccrs_sequencer;
   import ccrs_pkg::*;
   localparam int T1 = 16;
   localparam int T2 = 8;
   logic        i_ref_clk  = 1'b0;
   logic        i_rst      = 1'b1;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [7:0]  paddr      = 8'h00;
   logic [31:0] pwdata     = 32'h0;
   logic [15:0] pcm        = 16'h0000;
   logic [31:0] prdata, rd;
   logic [15:0] enc;
   logic        pready, pslverr, err, tick, fsync, mute, fs_en, cal_run;
   int          miscompares = 0;
   int          checks      = 0;
   int          cal_ticks   = 0;
   int          mute_ticks  = 0;
   int          dark        = 0;
   int          c0, m0, d0, n;
   logic [15:0] smp [3]    = '{16'h8000, 16'h7fff, 16'h0000};
   logic [15:0] expt [4][3] = '{'{16'h8000, 16'h7fff, 16'h0000}, '{16'h00, 16'hff, 16'h80},
                                '{16'h00, 16'h80, 16'hff}, '{16'h2a, 16'haa, 16'hd5}};
   always #5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      if (tick === 1'b1 && cal_run === 1'b1) cal_ticks <= cal_ticks + 1;
      if (tick === 1'b1 && mute === 1'b1) mute_ticks <= mute_ticks + 1;
      if (fs_en !== 1'b1) dark <= dark + 1;
   end
   ccrs_sequencer #(.FRAME_SAMPLES(2), .TMO_FIRST(T1), .TMO_LATER(T2)) uut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .i_sample_tick(tick), .i_frame_sync(fsync), .i_pcm_sample(pcm),
      .o_enc_sample(enc), .o_mute(mute), .o_frame_sync_en(fs_en), .o_cal_run(cal_run));
   ccrs_host_model #(.TICK_DIV(4), .FRAME_SAMPLES(2)) host (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .o_sample_tick(tick), .o_frame_sync(fsync));
   task conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int k;
      @(posedge i_ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         miscompares++;
         conclude();
      end
   endtask
   // host polls like firmware would, so bus traffic overlaps the intervals
   task poll(input int b, input logic v);
      int k;
      k = 0;
      do begin
         xfer(CCRS_STATUS_OFS, 1'b0, 32'h0);
         k++;
      end while (rd[b] !== v && k < 1000);
      chk("status bit", {31'h0, v}, {31'h0, rd[b]});
      if (k >= 1000) conclude();
   endtask
   initial begin
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      xfer(CCRS_CTRL_OFS, 1'b0, 32'h0);
      chk("ctrl reset", {30'h0, CCRS_CTRL_RST}, rd);
      xfer(CCRS_FMT_OFS, 1'b0, 32'h0);
      chk("fmt reset", {26'h0, CCRS_FMT_RST}, rd);
      xfer(CCRS_STATUS_OFS, 1'b0, 32'h0);
      chk("status reset", 32'h0, rd);
      chk("frame sync enable", 32'h1, {31'h0, fs_en});
      xfer(CCRS_TEST_OFS, 1'b0, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      xfer(CCRS_FMT_OFS, 1'b1, 32'h3f);
      xfer(CCRS_FMT_OFS, 1'b0, 32'h0);
      chk("fmt closed", 32'h0, rd);
      $display("test reset and lock done");
      xfer(CCRS_CTRL_OFS, 1'b1, 32'h1);
      for (int e = 0; e < 4; e++) begin
         xfer(CCRS_FMT_OFS, 1'b1, 32'(e) << CCRS_FMT_ENC_LSB);
         for (int s = 0; s < 3; s++) begin
            pcm <= smp[s];
            repeat (3) @(posedge i_ref_clk);
            chk("encoded", {16'h0, expt[e][s]}, {16'h0, (e == 0) ? enc : {8'h0, enc[7:0]}});
         end
      end
      $display("test encodings done");
      xfer(CCRS_CTRL_OFS, 1'b1, 32'h3);
      c0 = cal_ticks;
      xfer(CCRS_CTRL_OFS, 1'b1, 32'h2);
      xfer(CCRS_STATUS_OFS, 1'b0, 32'h0);
      chk("cal start", 32'h1, rd & 32'h7);
      poll(CCRS_ST_CIP_BIT, 1'b0);
      chk("cal ticks", 32'd384, 32'(cal_ticks - c0));
      xfer(CCRS_CTRL_OFS, 1'b1, 32'h1);
      m0 = mute_ticks;
      c0 = cal_ticks;
      xfer(CCRS_CTRL_OFS, 1'b1, 32'h0);
      xfer(CCRS_STATUS_OFS, 1'b0, 32'h0);
      chk("mute start", 32'h5, rd & 32'h7);
      poll(CCRS_ST_CIP_BIT, 1'b0);
      chk("mute ticks", 32'd128, 32'(mute_ticks - m0));
      chk("no cal", 32'h0, 32'(cal_ticks - c0));
      $display("test intervals done");
      for (int k = 0; k < 2; k++) begin
         d0 = dark;
         xfer(CCRS_CTRL_OFS, 1'b1, 32'h1);
         xfer(CCRS_FMT_OFS, 1'b1, (k == 0) ? 32'h09 : 32'h02);
         poll(CCRS_ST_RSY_BIT, 1'b1);
         chk("port disabled", 32'h0, {31'h0, fs_en});
         n = 0;
         while (fs_en !== 1'b1 && n < 300) begin
            @(posedge i_ref_clk);
            n++;
         end
         if (n >= 300) begin
            miscompares++;
            conclude();
         end
         chk("dark long", 32'h1, {31'h0, (dark - d0) >= ((k == 0) ? T1 : T2)});
         xfer(CCRS_FMT_OFS, 1'b0, 32'h0);
         chk("fmt open", (k == 0) ? 32'h09 : 32'h02, rd);
         xfer(CCRS_CTRL_OFS, 1'b1, 32'h0);
         poll(CCRS_ST_CIP_BIT, 1'b1);
         poll(CCRS_ST_CIP_BIT, 1'b0);
      end
      $display("test rate change done");
      conclude();
   end
endmodule
